// File: design/bstim_pkg.sv
// constants, field layouts and carrier types of the buffered sixteen-bit timer
package bstim_pkg;

    // ****************************************************************
    // register byte offsets
    // ****************************************************************
    localparam logic [7:0] OFS_COUNTER_CONTROL = 8'h00;
    localparam logic [7:0] OFS_COUNT_LOW_BYTE = 8'h04;
    localparam logic [7:0] OFS_COUNT_HIGH_BYTE = 8'h08;
    localparam logic [7:0] OFS_PERIPHERAL_FLAG_REG_ONE = 8'h0C;
    localparam logic [7:0] OFS_PERIPHERAL_ENABLE_REG_ONE = 8'h10;
    localparam logic [7:0] OFS_OSCILLATOR_CONTROL = 8'h14;
    localparam logic [7:0] OFS_OSC_CONFIG = 8'h18;
    localparam logic [7:0] OFS_COMPARE_MODES = 8'h1C;
    localparam logic [7:0] OFS_POWER_STATUS = 8'h20;

    // ****************************************************************
    // field positions and codes
    // ****************************************************************
    localparam int OVERFLOW_FLAG_BIT = 0;
    localparam int OVERFLOW_IRQ_ENABLE_BIT = 0;
    localparam int AUX_OSC_LOW_DRIVE_BIT = 0;
    localparam int IDLE_ON_SLEEP_BIT = 7;
    localparam int CMP_TWO_MODE_LSB = 4;
    localparam logic [1:0] SCS_AUX_OSC = 2'h1;
    localparam logic [3:0] CMP_MODE_SPECIAL_EVENT = 4'hB;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0] COUNTER_CONTROL_RST = 8'h00;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic AUX_OSC_LOW_DRIVE_RST = 1'b0;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef struct packed {
        logic wideAccessEnable;     // bit 7
        logic auxClockActive;       // bit 6, read only
        logic [1:0] inputDivideSelect;
        logic auxOscEnable;         // bit 3
        logic externalSyncBypass;   // bit 2
        logic externalClockSelect;  // bit 1
        logic counterRun;           // bit 0
    } bstim_ctrl_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } bstim_ahb_req_s;

    typedef enum logic [1:0] {
        PM_PRI_RUN,
        PM_SEC_RUN,
        PM_SEC_IDLE,
        PM_SLEEP
    } bstim_pm_e;

endpackage : bstim_pkg

// File: design/bstim_sync.sv
// two-flop synchroniser for asynchronous input levels
`timescale 1ns/1ps
module bstim_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,              // system clock
    input wire logic arst_n,               // async reset, active low
    input wire logic [WIDTH-1:0] asyncIn,  // levels from outside the domain
    output logic [WIDTH-1:0] syncOut       // synchronised levels
);

    logic [WIDTH-1:0] stage1_q;

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stage1_q <= '0;
            syncOut <= '0;
        end
        else
        begin
            stage1_q <= asyncIn;
            syncOut <= stage1_q;
        end
    end

endmodule : bstim_sync

// File: design/bstim_prescale.sv
// input prescaler: passes one tick in 1, 2, 4 or 8
`timescale 1ns/1ps
module bstim_prescale #(
    parameter int SEL_W = 2
) (
    input wire logic clk_sys,              // system clock
    input wire logic arst_n,               // async reset, active low
    input wire logic tickIn,               // source tick, one cycle
    input wire logic [SEL_W-1:0] divSel,   // divide select code
    input wire logic clear,                // clear the prescale count
    output logic tickOut                   // divided tick, combinational
);

    localparam int CNT_W = (1 << SEL_W) - 1;

    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] mask;

    // code n divides by two to the n
    assign mask = CNT_W'((1 << divSel) - 1);
    assign tickOut = tickIn && ((count_q & mask) == mask);

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            count_q <= '0;
        end
        else if (clear)
        begin
            count_q <= '0;
        end
        else if (tickIn)
        begin
            count_q <= (tickOut) ? '0 : CNT_W'(count_q + 1'b1);
        end
    end

endmodule : bstim_prescale

// File: design/bstim_top.sv
// buffered sixteen-bit timer with AHB-Lite register slave
`timescale 1ns/1ps
module bstim_top (
    input wire logic clk_sys,              // system clock, 50 MHz
    input wire logic arst_n,               // async reset, active low
    input wire logic hsel,                 // slave select
    input wire logic [31:0] haddr,         // byte address
    input wire logic [1:0] htrans,         // transfer type
    input wire logic hwrite,               // write when high
    input wire logic [2:0] hsize,          // transfer size
    input wire logic [31:0] hwdata,        // write data
    input wire logic hready,               // bus ready
    output logic hreadyout,                // slave ready
    output logic hresp,                    // response, always okay
    output logic [31:0] hrdata,            // read data
    input wire logic extClkPin,            // external count clock pin
    input wire logic auxOscIn,             // crystal oscillator clock
    input wire logic clockFail,            // clock monitor failure level
    input wire logic cmpOneEvent,          // compare unit one match pulse
    input wire logic cmpTwoEvent,          // compare unit two match pulse
    input wire logic sleepExec,            // sleep instruction pulse
    input wire logic wakeEvent,            // wake-up pulse
    output logic overflowIrq,              // overflow interrupt request
    output logic auxOscEnable,             // crystal oscillator enable
    output logic auxOscLowDrive,           // crystal drive level select
    output logic sysClkFromAux,            // system clock mux select
    output logic [1:0] powerState          // current power-managed state
);

    // ****************************************************************
    // registers and wires
    // ****************************************************************
    bstim_pkg::bstim_ctrl_s ctrl_q;
    bstim_pkg::bstim_ahb_req_s req_q;
    bstim_pkg::bstim_pm_e pm_q;
    logic [15:0] count_q;
    logic [7:0] highBuf_q;
    logic overflowFlag_q;
    logic overflowIrqEnable_q;
    logic idleOnSleep_q;
    logic [1:0] sysClockSelect_q;
    logic [3:0] cmpOneMode_q;
    logic [3:0] cmpTwoMode_q;
    logic srcPrev_q;
    logic [1:0] pinSync;
    logic clockFailSync;
    logic srcLevel;
    logic srcRise;
    logic rawTick;
    logic scaledTick;
    logic addrPhase;
    logic wrLow;
    logic wrHigh;
    logic trigOne;
    logic trigTwo;
    logic trigReset;
    logic wrap;
    logic [31:0] rdData;

    // ****************************************************************
    // bus address phase
    // ****************************************************************
    assign addrPhase = hsel && hready && htrans[1];
    assign wrLow = req_q.valid && req_q.write && (req_q.addr == bstim_pkg::OFS_COUNT_LOW_BYTE);
    assign wrHigh = req_q.valid && req_q.write
        && (req_q.addr == bstim_pkg::OFS_COUNT_HIGH_BYTE);

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            req_q <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (hready)
            begin
                req_q.valid <= addrPhase;
                req_q.write <= hwrite;
                req_q.addr <= haddr[7:0];
            end
        end
    end

    // ****************************************************************
    // read mux
    // ****************************************************************
    always_comb
    begin
        rdData = '0;
        case (haddr[7:0])
            bstim_pkg::OFS_COUNTER_CONTROL:
            begin
                rdData[7:0] = ctrl_q;
            end
            bstim_pkg::OFS_COUNT_LOW_BYTE:
            begin
                rdData[7:0] = count_q[7:0];
            end
            bstim_pkg::OFS_COUNT_HIGH_BYTE:
            begin
                rdData[7:0] = ctrl_q.wideAccessEnable ? highBuf_q : count_q[15:8];
            end
            bstim_pkg::OFS_PERIPHERAL_FLAG_REG_ONE:
            begin
                rdData[bstim_pkg::OVERFLOW_FLAG_BIT] = overflowFlag_q;
            end
            bstim_pkg::OFS_PERIPHERAL_ENABLE_REG_ONE:
            begin
                rdData[bstim_pkg::OVERFLOW_IRQ_ENABLE_BIT] = overflowIrqEnable_q;
            end
            bstim_pkg::OFS_OSCILLATOR_CONTROL:
            begin
                rdData[bstim_pkg::IDLE_ON_SLEEP_BIT] = idleOnSleep_q;
                rdData[1:0] = sysClockSelect_q;
            end
            bstim_pkg::OFS_OSC_CONFIG:
            begin
                rdData[bstim_pkg::AUX_OSC_LOW_DRIVE_BIT] = auxOscLowDrive;
            end
            bstim_pkg::OFS_COMPARE_MODES:
            begin
                rdData[7:0] = {cmpTwoMode_q, cmpOneMode_q};
            end
            bstim_pkg::OFS_POWER_STATUS:
            begin
                rdData[1:0] = pm_q;
            end
            default:
            begin
                rdData = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hrdata <= '0;
        end
        else if (addrPhase && !hwrite)
        begin
            hrdata <= rdData;
        end
    end

    // ****************************************************************
    // control and configuration registers
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_q <= bstim_pkg::COUNTER_CONTROL_RST;
            overflowIrqEnable_q <= 1'b0;
            idleOnSleep_q <= 1'b0;
            sysClockSelect_q <= '0;
            cmpOneMode_q <= '0;
            cmpTwoMode_q <= '0;
            auxOscLowDrive <= bstim_pkg::AUX_OSC_LOW_DRIVE_RST;
        end
        else
        begin
            ctrl_q.auxClockActive <= (pm_q == bstim_pkg::PM_SEC_RUN)
                || (pm_q == bstim_pkg::PM_SEC_IDLE);
            if (req_q.valid && req_q.write)
            begin
                case (req_q.addr)
                    bstim_pkg::OFS_COUNTER_CONTROL:
                    begin
                        ctrl_q.wideAccessEnable <= hwdata[7];
                        ctrl_q.inputDivideSelect <= hwdata[5:4];
                        ctrl_q.auxOscEnable <= hwdata[3];
                        ctrl_q.externalSyncBypass <= hwdata[2];
                        ctrl_q.externalClockSelect <= hwdata[1];
                        ctrl_q.counterRun <= hwdata[0];
                    end
                    bstim_pkg::OFS_PERIPHERAL_ENABLE_REG_ONE:
                    begin
                        overflowIrqEnable_q <= hwdata[bstim_pkg::OVERFLOW_IRQ_ENABLE_BIT];
                    end
                    bstim_pkg::OFS_OSCILLATOR_CONTROL:
                    begin
                        idleOnSleep_q <= hwdata[bstim_pkg::IDLE_ON_SLEEP_BIT];
                        sysClockSelect_q <= hwdata[1:0];
                    end
                    bstim_pkg::OFS_OSC_CONFIG:
                    begin
                        auxOscLowDrive <= hwdata[bstim_pkg::AUX_OSC_LOW_DRIVE_BIT];
                    end
                    bstim_pkg::OFS_COMPARE_MODES:
                    begin
                        cmpOneMode_q <= hwdata[3:0];
                        cmpTwoMode_q <= hwdata[bstim_pkg::CMP_TWO_MODE_LSB +: 4];
                    end
                    default:
                    begin
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // clock source selection and prescaler
    // ****************************************************************
    bstim_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .asyncIn({clockFail, auxOscIn, extClkPin}),
        .syncOut({clockFailSync, pinSync})
    );

    // crystal replaces the pin when enabled
    assign srcLevel = ctrl_q.auxOscEnable ? pinSync[1] : pinSync[0];
    assign srcRise = srcLevel && !srcPrev_q;
    // bypass bit only matters with external clock
    assign rawTick = ctrl_q.externalClockSelect ? srcRise : 1'b1;

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            srcPrev_q <= 1'b0;
        end
        else
        begin
            srcPrev_q <= srcLevel;
        end
    end

    // divide by 1, 2, 4 or 8
    bstim_prescale #(
        .SEL_W(2)
    ) u_prescale (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .tickIn(rawTick && ctrl_q.counterRun),
        .divSel(ctrl_q.inputDivideSelect),
        .clear(wrLow),
        .tickOut(scaledTick)
    );

    // ****************************************************************
    // counter, buffer and overflow flag
    // ****************************************************************
    // special event trigger from either unit
    assign trigOne = cmpOneEvent && (cmpOneMode_q == bstim_pkg::CMP_MODE_SPECIAL_EVENT);
    assign trigTwo = cmpTwoEvent && (cmpTwoMode_q == bstim_pkg::CMP_MODE_SPECIAL_EVENT);
    // not applied in unsynchronised counter mode
    assign trigReset = (trigOne || trigTwo)
        && !(ctrl_q.externalClockSelect && ctrl_q.externalSyncBypass);
    assign wrap = scaledTick && ctrl_q.counterRun && (count_q == bstim_pkg::COUNT_MAX)
        && !wrLow && !wrHigh && !trigReset;

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            count_q <= bstim_pkg::COUNT_RST;
        end
        else if (wrLow)
        begin
            if (ctrl_q.wideAccessEnable)
            begin
                count_q <= {highBuf_q, hwdata[7:0]};
            end
            else
            begin
                count_q[7:0] <= hwdata[7:0];
            end
        end
        else if (wrHigh && !ctrl_q.wideAccessEnable)
        begin
            count_q[15:8] <= hwdata[7:0];
        end
        else if (trigReset && !wrHigh)
        begin
            count_q <= bstim_pkg::COUNT_RST;
        end
        else if (scaledTick && ctrl_q.counterRun && !wrHigh)
        begin
            count_q <= 16'(count_q + 16'h0001);
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            highBuf_q <= bstim_pkg::BYTE_RST;
        end
        else if (wrHigh && ctrl_q.wideAccessEnable)
        begin
            highBuf_q <= hwdata[7:0];
        end
        else if (addrPhase && !hwrite && ctrl_q.wideAccessEnable
            && (haddr[7:0] == bstim_pkg::OFS_COUNT_LOW_BYTE))
        begin
            highBuf_q <= count_q[15:8];
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            overflowFlag_q <= 1'b0;
            overflowIrq <= 1'b0;
        end
        else
        begin
            if (wrap)
            begin
                overflowFlag_q <= 1'b1;
            end
            else if (req_q.valid && req_q.write
                && req_q.addr == bstim_pkg::OFS_PERIPHERAL_FLAG_REG_ONE)
            begin
                overflowFlag_q <= hwdata[bstim_pkg::OVERFLOW_FLAG_BIT];
            end
            overflowIrq <= (overflowFlag_q || wrap) && overflowIrqEnable_q;
        end
    end

    // ****************************************************************
    // oscillator enable and power-managed state
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            auxOscEnable <= 1'b0;
            sysClkFromAux <= 1'b0;
            powerState <= '0;
        end
        else
        begin
            auxOscEnable <= ctrl_q.auxOscEnable;
            sysClkFromAux <= (pm_q == bstim_pkg::PM_SEC_RUN) || (pm_q == bstim_pkg::PM_SEC_IDLE);
            powerState <= pm_q;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pm_q <= bstim_pkg::PM_PRI_RUN;
        end
        else if (clockFailSync)
        begin
            pm_q <= bstim_pkg::PM_PRI_RUN;
        end
        else
        begin
            case (pm_q)
                bstim_pkg::PM_PRI_RUN:
                begin
                    if (sysClockSelect_q == bstim_pkg::SCS_AUX_OSC && ctrl_q.auxOscEnable)
                    begin
                        pm_q <= bstim_pkg::PM_SEC_RUN;
                    end
                    else if (sleepExec)
                    begin
                        pm_q <= bstim_pkg::PM_SLEEP;
                    end
                end
                bstim_pkg::PM_SEC_RUN:
                begin
                    if (sleepExec && !idleOnSleep_q)
                    begin
                        pm_q <= bstim_pkg::PM_SEC_IDLE;
                    end
                    else if (sleepExec)
                    begin
                        pm_q <= bstim_pkg::PM_SLEEP;
                    end
                    else if (sysClockSelect_q != bstim_pkg::SCS_AUX_OSC)
                    begin
                        pm_q <= bstim_pkg::PM_PRI_RUN;
                    end
                end
                bstim_pkg::PM_SEC_IDLE:
                begin
                    if (wakeEvent)
                    begin
                        pm_q <= bstim_pkg::PM_SEC_RUN;
                    end
                end
                bstim_pkg::PM_SLEEP:
                begin
                    if (wakeEvent)
                    begin
                        pm_q <= bstim_pkg::PM_PRI_RUN;
                    end
                end
                default:
                begin
                    pm_q <= bstim_pkg::PM_PRI_RUN;
                end
            endcase
        end
    end

endmodule : bstim_top

// File: verif/bstim_cmp_model.sv
// compare unit model: one-cycle trigger pulses
`timescale 1ns/1ps
module bstim_cmp_model (
    input wire logic clk_sys, // clock
    input wire logic arst_n, // reset
    input wire logic [1:0] fire, // requests, unit two in bit 1
    output logic [1:0] matchPulse // trigger pulses
);
    logic [1:0] fireQ;
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            {fireQ, matchPulse} <= 4'h0;
        else
        begin
            fireQ <= fire;
            matchPulse <= fire & ~fireQ;
        end
    end
endmodule : bstim_cmp_model

// File: verif/bstim_top_sva.sv
// assertion checker on the timer's bus and status ports
`timescale 1ns/1ps
module bstim_top_sva (
    input wire logic clk_sys, // clock
    input wire logic arst_n, // reset
    input wire logic hsel, // select
    input wire logic [31:0] haddr, // address
    input wire logic [1:0] htrans, // type
    input wire logic hwrite, // write
    input wire logic [31:0] hwdata, // wdata
    input wire logic hreadyout, // ready
    input wire logic hresp, // response
    input wire logic [31:0] hrdata, // rdata
    input wire logic clockFail, // failure
    input wire logic sleepExec, // sleep
    input wire logic overflowIrq, // request
    input wire logic auxOscEnable, // osc enable
    input wire logic auxOscLowDrive, // drive
    input wire logic sysClkFromAux, // mux
    input wire logic [1:0] powerState // state
);
    logic wrQ, ctl3Q, enQ, drvQ, idleQ;
    logic [7:0] adrQ;
    wire logic take = hsel && hreadyout && htrans[1];
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // mirrors of written bits
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            {wrQ, ctl3Q, enQ, drvQ, idleQ, adrQ} <= 13'h0000;
        else
        begin
            wrQ <= take && hwrite;
            adrQ <= haddr[7:0];
            ctl3Q <= (wrQ && adrQ == bstim_pkg::OFS_COUNTER_CONTROL) ? hwdata[3] : ctl3Q;
            enQ <= (wrQ && adrQ == bstim_pkg::OFS_PERIPHERAL_ENABLE_REG_ONE) ? hwdata[0] : enQ;
            drvQ <= (wrQ && adrQ == bstim_pkg::OFS_OSC_CONFIG) ? hwdata[0] : drvQ;
            idleQ <= (wrQ && adrQ == bstim_pkg::OFS_OSCILLATOR_CONTROL) ? hwdata[7] : idleQ;
        end
    end
    sequence s_rdCtl;
        take && !hwrite && haddr[7:0] == bstim_pkg::OFS_COUNTER_CONTROL;
    endsequence
    // ****************************************************************
    // assertions
    // ****************************************************************
    AST_BUS_OKAY:
        assert property (hreadyout && !hresp) else $error("slave stalled or errored");
    AST_OSC_ENABLE:
        assert property (auxOscEnable == $past(ctl3Q)) else $error("osc enable off");
    AST_DRIVE_LEVEL:
        assert property (auxOscLowDrive == drvQ) else $error("drive level off");
    AST_IRQ_MASKED:
        assert property (!enQ && !$past(enQ) |-> !overflowIrq) else $error("masked request");
    AST_CLK_MUX:
        assert property (sysClkFromAux == (powerState inside
            {bstim_pkg::PM_SEC_RUN, bstim_pkg::PM_SEC_IDLE})) else $error("clock mux off");
    AST_SEC_IDLE:
        assert property (powerState == bstim_pkg::PM_SEC_RUN && sleepExec && !idleQ
            && !clockFail |-> ##[1:2] powerState == bstim_pkg::PM_SEC_IDLE)
            else $error("no secondary idle");
    AST_FAILOVER:
        assert property (clockFail [*5] |-> powerState == bstim_pkg::PM_PRI_RUN
            && !sysClkFromAux) else $error("no failover");
    AST_STATUS_SET:
        assert property ((sysClkFromAux && powerState != bstim_pkg::PM_PRI_RUN) [*3]
            ##0 s_rdCtl |=> hrdata[6]) else $error("status bit clear");
    AST_STATUS_CLEAR:
        assert property ((!sysClkFromAux && powerState == bstim_pkg::PM_PRI_RUN) [*3]
            ##0 s_rdCtl |=> !hrdata[6]) else $error("status bit set");
endmodule : bstim_top_sva
bind bstim_top bstim_top_sva chk (.clk_sys, .arst_n, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hreadyout, .hresp, .hrdata, .clockFail, .sleepExec, .overflowIrq,
    .auxOscEnable, .auxOscLowDrive, .sysClkFromAux, .powerState);

// File: verif/test_buffered_sixteen_bit_timer.sv
// self-checking bench for the buffered sixteen-bit timer
`timescale 1ns/1ps
module test_buffered_sixteen_bit_timer;
    localparam logic [7:0] CT = bstim_pkg::OFS_COUNTER_CONTROL,
        LO = bstim_pkg::OFS_COUNT_LOW_BYTE, HI = bstim_pkg::OFS_COUNT_HIGH_BYTE,
        FL = bstim_pkg::OFS_PERIPHERAL_FLAG_REG_ONE, OC = bstim_pkg::OFS_OSCILLATOR_CONTROL,
        PS = bstim_pkg::OFS_POWER_STATUS;
    logic clk_sys = 1'b0, arst_n = 1'b0, hwrite = 1'b0, extClkPin = 1'b0, auxOscIn = 1'b0;
    logic clockFail = 1'b0, sleepExec = 1'b0, wakeEvent = 1'b0, hreadyout, hresp;
    logic overflowIrq, auxOscEnable, auxOscLowDrive, sysClkFromAux;
    logic [1:0] htrans = 2'h0, fire = 2'h0, pulse, powerState;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, v, w;
    int err_total = 0, num_checks = 0, cyc = 0, wrCyc, t0, n, k, i;
    integer seed;
    initial forever #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;
    bstim_top dut (.clk_sys, .arst_n, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .extClkPin, .auxOscIn,
        .clockFail, .cmpOneEvent(pulse[0]), .cmpTwoEvent(pulse[1]), .sleepExec, .wakeEvent,
        .overflowIrq, .auxOscEnable, .auxOscLowDrive, .sysClkFromAux, .powerState);
    bstim_cmp_model cmp (.clk_sys, .arst_n, .fire, .matchPulse(pulse));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // single transfer plus one idle cycle
    task automatic xfer(input logic [7:0] a, input logic [31:0] d, input logic w = 1'b1);
        haddr <= 32'(a);
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
        wrCyc = cyc;
        @(posedge clk_sys);
    endtask : xfer
    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 32'h0, 1'b0);
        check(rd, exp);
    endtask : rdChk
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        test_done();
    end
    initial
    begin
        seed = 32'h22C3A9C3;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        rdChk(CT, 32'h0);
        check(32'(auxOscLowDrive), 32'h0);
        rdChk(8'hFC, 32'h0);
        v = $random(seed);
        w = $random(seed);
        xfer(HI, 32'(v[15:8]));
        xfer(LO, 32'(v[7:0]));
        rdChk(HI, 32'(v[15:8]));
        xfer(CT, 32'h80);
        xfer(HI, 32'(w[15:8]));
        rdChk(HI, 32'(w[15:8]));
        rdChk(LO, 32'(v[7:0]));
        rdChk(HI, 32'(v[15:8]));
        xfer(HI, 32'(w[15:8]));
        xfer(LO, 32'(w[7:0]));
        xfer(CT, 32'h0);
        rdChk(HI, 32'(w[15:8]));
        rdChk(LO, 32'(w[7:0]));
        $display("byte access test done");
        xfer(bstim_pkg::OFS_PERIPHERAL_ENABLE_REG_ONE, 32'h1);
        for (i = 0; i < 4; i++)
        begin
            xfer(HI, 32'hFF);
            xfer(LO, 32'hF0);
            xfer(FL, 32'h0);
            xfer(CT, 32'(i * 16 + 1));
            t0 = wrCyc;
            repeat (130 + ($random(seed) & 63)) @(posedge clk_sys);
            xfer(CT, 32'h0);
            n = (wrCyc - t0) >> i;
            k = (65520 + n) % 65536;
            rdChk(LO, 32'(k & 255));
            rdChk(HI, 32'(k >> 8));
            rdChk(FL, 32'(n >= 16));
            check(32'(overflowIrq), 32'(n >= 16));
            repeat (5) @(posedge clk_sys);
            rdChk(LO, 32'(k & 255));
        end
        xfer(FL, 32'h0);
        $display("count and overflow test done");
        for (i = 0; i < 2; i++)
        begin
            xfer(LO, 32'h0);
            xfer(HI, 32'h0);
            xfer(CT, 32'(i * 8 + 3));
            k = 3 + ($random(seed) & 7);
            for (n = 0; n < k * 4; n++)
            begin
                auxOscIn <= !n[0];
                extClkPin <= !n[1];
                repeat (4) @(posedge clk_sys);
            end
            xfer(CT, 32'h0);
            rdChk(LO, 32'(k << i));
        end
        for (i = 0; i < 4; i++)
        begin
            xfer(bstim_pkg::OFS_COMPARE_MODES, i == 3 ? 32'hAA : 32'hBB);
            xfer(CT, i == 2 ? 32'h6 : 32'h0);
            xfer(HI, 32'hFF);
            xfer(LO, 32'hFF);
            fire <= i[0] ? 2'h1 : 2'h2;
            repeat (4) @(posedge clk_sys);
            fire <= 2'h0;
            rdChk(LO, i < 2 ? 32'h0 : 32'hFF);
            rdChk(FL, 32'h0);
        end
        $display("clock source and trigger test done");
        xfer(bstim_pkg::OFS_OSC_CONFIG, 32'h1);
        check(32'(auxOscLowDrive), 32'h1);
        xfer(CT, 32'h8);
        xfer(OC, 32'h1);
        check(32'(auxOscEnable), 32'h1);
        rdChk(PS, 32'h1);
        rdChk(CT, 32'h48);
        sleepExec <= 1'b1;
        @(posedge clk_sys);
        sleepExec <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rdChk(PS, 32'h2);
        wakeEvent <= 1'b1;
        @(posedge clk_sys);
        wakeEvent <= 1'b0;
        clockFail <= 1'b1;
        repeat (6) @(posedge clk_sys);
        rdChk(PS, 32'h0);
        rdChk(CT, 32'h8);
        clockFail <= 1'b0;
        xfer(OC, 32'h0);
        xfer(CT, 32'h0);
        repeat (2) @(posedge clk_sys);
        check(32'(auxOscEnable), 32'h0);
        $display("power state test done");
        test_done();
    end
endmodule : test_buffered_sixteen_bit_timer
